//--- design/adc_pwr_pkg.sv
// Shared constants and types for the converter power and reference control
package adc_pwr_pkg;
    // Clock and conversion timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OSC_PERIOD_PS = 250000;
    localparam int STEP_CYCLES = (OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REF_SETTLE_MS = 12;
    // Divide first so the product stays inside a 32-bit int
    localparam int REF_SETTLE_CYCLES = REF_SETTLE_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int STEP_W = 6;
    localparam int SETTLE_W = 22;

    // Result format
    localparam int RES_BITS = 14;
    localparam int BYTE_BITS = 8;
    localparam int LOW_BITS = 6;
    localparam logic [1:0] SUB_BITS = 2'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;

    // Slave address
    localparam logic [2:0] ADDR_FIXED = 3'h3;

    // Reference status codes
    localparam logic [1:0] REF_OFF = 2'h0;
    localparam logic [1:0] REF_PENDING = 2'h1;
    localparam logic [1:0] REF_POWERING = 2'h2;
    localparam logic [1:0] REF_SETTLED = 2'h3;

    // Serial control states
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_CONVERT = 8'h08,
        ST_TX_MSB = 8'h10,
        ST_ACK_MSB = 8'h20,
        ST_TX_LSB = 8'h40,
        ST_ACK_LSB = 8'h80
    } ctrl_state_type;
endpackage : adc_pwr_pkg

//--- design/line_events.sv
// Start, stop and clock edge detection on the two-wire bus lines
`timescale 1ns/1ps
module line_events
    import adc_pwr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    // Events
    output logic start_o,
    output logic stop_o,
    output logic rise_o,
    output logic fall_o
);
    logic scl_reg;
    logic sda_reg;

    // Lines idle high
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_reg <= scl_i;
            sda_reg <= sda_i;
        end
    end

    assign start_o = scl_reg & scl_i & sda_reg & ~sda_i;
    assign stop_o = scl_reg & scl_i & ~sda_reg & sda_i;
    assign rise_o = ~scl_reg & scl_i;
    assign fall_o = scl_reg & ~scl_i;
endmodule : line_events

//--- design/sar_converter.sv
// Successive-approximation sequencer paced by the internal oscillator
`timescale 1ns/1ps
module sar_converter
    import adc_pwr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic comparator_i,
    // Results
    output logic done_o,
    output logic [RES_BITS-1:0] dac_code_o,
    output logic [RES_BITS-1:0] result_o
);
    logic [RES_BITS-1:0] mask_reg;
    logic [STEP_W-1:0] step_reg;
    logic busy_reg;
    logic [RES_BITS-1:0] kept;

    // Comparator high means input at or above the trial level
    assign kept = comparator_i ? dac_code_o : (dac_code_o & ~mask_reg);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_reg <= '0;
            step_reg <= '0;
            busy_reg <= 1'b0;
            done_o <= 1'b0;
            dac_code_o <= '0;
            result_o <= '0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                busy_reg <= 1'b1;
                step_reg <= '0;
                mask_reg <= {1'b1, {(RES_BITS-1){1'b0}}};
                dac_code_o <= {1'b1, {(RES_BITS-1){1'b0}}};
            end else if (busy_reg) begin
                if (step_reg == STEP_W'(STEP_CYCLES - 1)) begin
                    step_reg <= '0;
                    mask_reg <= mask_reg >> 1;
                    dac_code_o <= kept | (mask_reg >> 1);
                    if (mask_reg[0]) begin
                        busy_reg <= 1'b0;
                        done_o <= 1'b1;
                        result_o <= kept;
                    end
                end else begin
                    step_reg <= step_reg + 1'b1;
                end
            end
        end
    end
endmodule : sar_converter

//--- design/adc_power_shutdown_control.sv
// Serial slave, power sequencing and reference shutdown control
//
// Summary of operation
// - Reset leaves core and reference powered down.
// - Bus watcher always runs, even while the core sleeps.
// - Own slave address powers up the conversion core.
// - Core powers down by itself once a conversion completes.
// - Core power-down is the same in either reference mode.
// - Internal reference stays on between conversions unless shutdown armed.
// - External reference mode ignores the read/write bit.
// - Read/write 1 keeps reference on; 0 arms a pending shutdown.
// - Armed internal reference shuts down on master not-acknowledge.
// - Shut down reference disables both reference and its buffer.
// - Reference power-up starts on ninth falling edge of address.
// - Straight binary 14-bit result, step equals reference over 2^14.
// - Code transitions sit half a step above integer levels.
// - Adjust input tied to supply selects external reference mode.
// - Address is fixed 011 then four select input bits.
// - Clock line held low during conversion, released when ready.
// - Result sent high byte first, then low bits and sub bits.
`timescale 1ns/1ps
module adc_power_shutdown_control
    import adc_pwr_pkg::*;
#(
    parameter int SETTLE_CYCLES = REF_SETTLE_CYCLES
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Two-wire bus, enables pull the line low
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    // Straps
    input wire logic [3:0] address_select_inputs_i,
    input wire logic reference_adjust_input_i,
    // Analog core
    input wire logic comparator_i,
    output logic [RES_BITS-1:0] dac_code_o,
    output logic dac_half_step_o,
    output logic core_power_o,
    // Reference
    output logic ref_enable_o,
    output logic ref_buffer_enable_o,
    output logic [1:0] ref_status_o,
    // Last result
    output logic [RES_BITS-1:0] result_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    ctrl_state_type st_reg;
    logic [3:0] bit_cnt_reg;
    logic [BYTE_BITS-1:0] shift_reg;
    logic [BYTE_BITS-1:0] tx_reg;
    logic rw_reg;
    logic ack_reg;
    logic conv_start_reg;
    logic armed_reg;
    logic [1:0] ref_state_reg;
    logic [SETTLE_W-1:0] settle_reg;
    logic start_ev;
    logic stop_ev;
    logic rise_ev;
    logic fall_ev;
    logic sar_done;
    logic [RES_BITS-1:0] sar_result;
    logic [RES_BITS-1:0] sar_dac;
    logic addr_ninth_fall;
    logic nack_ev;
    logic ext_mode;

    // Address compare: fixed upper bits, strapped lower bits
    function automatic logic addr_match(input logic [BYTE_BITS-1:0] b,
                                        input logic [3:0] sel);
        addr_match = (b[7:5] == ADDR_FIXED) && (b[4:1] == sel);
    endfunction : addr_match

    ////////////////////////////////////////////////////////////////////////
    // Sub blocks

    line_events u_events (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .start_o(start_ev),
        .stop_o(stop_ev),
        .rise_o(rise_ev),
        .fall_o(fall_ev)
    );

    sar_converter u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(conv_start_reg),
        .comparator_i(comparator_i),
        .done_o(sar_done),
        .dac_code_o(sar_dac),
        .result_o(sar_result)
    );

    // Adjust input high means external reference
    assign ext_mode = reference_adjust_input_i;
    assign addr_ninth_fall = (st_reg == ST_ADDR_ACK) && fall_ev;
    assign nack_ev = fall_ev && !ack_reg &&
                     ((st_reg == ST_ACK_MSB) || (st_reg == ST_ACK_LSB));

    ////////////////////////////////////////////////////////////////////////
    // Serial protocol

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= ST_IDLE;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            tx_reg <= '0;
            rw_reg <= 1'b1;
            ack_reg <= 1'b0;
            conv_start_reg <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            result_o <= '0;
        end else begin
            conv_start_reg <= 1'b0;
            if (start_ev) begin
                st_reg <= ST_ADDR;
                bit_cnt_reg <= '0;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
            end else if (stop_ev) begin
                st_reg <= ST_IDLE;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
            end else begin
                case (st_reg)
                    ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (rise_ev) begin
                            shift_reg <= {shift_reg[BYTE_BITS-2:0], sda_i};
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        end else if (fall_ev && bit_cnt_reg == BIT_LAST) begin
                            if (addr_match(shift_reg, address_select_inputs_i)) begin
                                sda_oe_o <= 1'b1;
                                rw_reg <= shift_reg[0];
                                st_reg <= ST_ADDR_ACK;
                            end else begin
                                st_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (fall_ev) begin
                            sda_oe_o <= 1'b0;
                            scl_oe_o <= 1'b1;
                            conv_start_reg <= 1'b1;
                            st_reg <= ST_CONVERT;
                        end
                    end
                    ST_CONVERT: begin
                        if (sar_done) begin
                            scl_oe_o <= 1'b0;
                            result_o <= sar_result;
                            tx_reg <= sar_result[RES_BITS-1:LOW_BITS];
                            sda_oe_o <= ~sar_result[RES_BITS-1];
                            bit_cnt_reg <= BIT_FIRST;
                            st_reg <= ST_TX_MSB;
                        end
                    end
                    ST_TX_MSB, ST_TX_LSB: begin
                        if (fall_ev) begin
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                            tx_reg <= tx_reg << 1;
                            if (bit_cnt_reg == BIT_LAST) begin
                                sda_oe_o <= 1'b0;
                                st_reg <= (st_reg == ST_TX_MSB) ? ST_ACK_MSB : ST_ACK_LSB;
                            end else begin
                                sda_oe_o <= ~tx_reg[BYTE_BITS-2];
                            end
                        end
                    end
                    ST_ACK_MSB: begin
                        if (rise_ev) begin
                            ack_reg <= ~sda_i;
                        end else if (fall_ev) begin
                            if (ack_reg) begin
                                tx_reg <= {result_o[LOW_BITS-1:0], SUB_BITS};
                                sda_oe_o <= ~result_o[LOW_BITS-1];
                                bit_cnt_reg <= BIT_FIRST;
                                st_reg <= ST_TX_LSB;
                            end else begin
                                st_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK_LSB: begin
                        if (rise_ev) begin
                            ack_reg <= ~sda_i;
                        end else if (fall_ev) begin
                            if (ack_reg) begin
                                // Acknowledged result starts the next conversion
                                scl_oe_o <= 1'b1;
                                conv_start_reg <= 1'b1;
                                st_reg <= ST_CONVERT;
                            end else begin
                                st_reg <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        st_reg <= ST_IDLE;
                        sda_oe_o <= 1'b0;
                        scl_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core power and converter outputs

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            core_power_o <= 1'b0;
            dac_code_o <= '0;
            dac_half_step_o <= 1'b0;
        end else begin
            dac_code_o <= sar_dac;
            dac_half_step_o <= core_power_o;
            if (st_reg == ST_ADDR && fall_ev && bit_cnt_reg == BIT_LAST &&
                addr_match(shift_reg, address_select_inputs_i)) begin
                core_power_o <= 1'b1;
            // Acked result wakes core for next conversion
            end else if (st_reg == ST_ACK_LSB && fall_ev && ack_reg) begin
                core_power_o <= 1'b1;
            end else if (sar_done || st_reg == ST_IDLE) begin
                core_power_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal reference control

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_state_reg <= REF_OFF;
            armed_reg <= 1'b0;
            settle_reg <= '0;
        end else if (ext_mode) begin
            // Direction bit ignored, internal reference off
            ref_state_reg <= REF_OFF;
            armed_reg <= 1'b0;
            settle_reg <= '0;
        end else if (nack_ev && armed_reg) begin
            ref_state_reg <= REF_OFF;
            armed_reg <= 1'b0;
        end else begin
            if (addr_ninth_fall) begin
                // Bit 0 arms, bit 1 disarms
                armed_reg <= ~rw_reg;
            end
            case (ref_state_reg)
                REF_OFF: begin
                    if (addr_ninth_fall) begin
                        ref_state_reg <= REF_POWERING;
                        settle_reg <= '0;
                    end
                end
                REF_POWERING: begin
                    if (settle_reg >= SETTLE_W'(SETTLE_CYCLES - 1)) begin
                        ref_state_reg <= REF_SETTLED;
                    end else begin
                        settle_reg <= settle_reg + 1'b1;
                    end
                end
                REF_SETTLED: begin
                    ref_state_reg <= REF_SETTLED;
                end
                default: begin
                    ref_state_reg <= REF_OFF;
                end
            endcase
        end
    end

    // Outputs lag the state by one cycle so they come from flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_enable_o <= 1'b0;
            ref_buffer_enable_o <= 1'b0;
            ref_status_o <= REF_OFF;
        end else begin
            ref_enable_o <= (ref_state_reg != REF_OFF) && !ext_mode;
            ref_buffer_enable_o <= (ref_state_reg != REF_OFF) && !ext_mode;
            if (ref_state_reg != REF_OFF && armed_reg) begin
                ref_status_o <= REF_PENDING;
            end else begin
                ref_status_o <= ref_state_reg;
            end
        end
    end

endmodule : adc_power_shutdown_control

//--- tb/adc_power_shutdown_control_sva.sv
// Concurrent checks on the power and reference control ports
`timescale 1ns/1ps
module adc_power_shutdown_control_sva
    import adc_pwr_pkg::*;
#(
    parameter int SETTLE_CYCLES = 20
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    // Straps and core
    input wire logic [3:0] address_select_inputs_i,
    input wire logic reference_adjust_input_i,
    input wire logic comparator_i,
    input wire logic [RES_BITS-1:0] dac_code_o,
    input wire logic dac_half_step_o,
    input wire logic core_power_o,
    // Reference and result
    input wire logic ref_enable_o,
    input wire logic ref_buffer_enable_o,
    input wire logic [1:0] ref_status_o,
    input wire logic [RES_BITS-1:0] result_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // Run lengths of stretch and power-up
    logic [11:0] str_cnt;
    logic [23:0] pw_cnt;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            str_cnt <= 12'h0;
        end else begin
            str_cnt <= scl_oe_o ? str_cnt + 12'h1 : 12'h0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pw_cnt <= 24'h0;
        end else begin
            pw_cnt <= (ref_status_o == REF_POWERING) ? pw_cnt + 24'h1 : 24'h0;
        end
    end
    ////////////////////////////////////////
    property p_reset_off;
        $fell(rst_i) |-> !core_power_o && !ref_enable_o && ref_status_o == REF_OFF
            && !scl_oe_o && !sda_oe_o;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("not idle after reset");
    // Two cycles of slack for a mode change
    property p_ext_off;
        reference_adjust_input_i [*3] |-> !ref_enable_o && ref_status_o == REF_OFF;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("reference on in external mode");
    property p_buf_follow;
        ref_buffer_enable_o == ref_enable_o;
    endproperty
    a_buf_follow: assert property (p_buf_follow) else $error("buffer differs from ref");
    property p_off_disabled;
        (ref_status_o == REF_OFF) [*2] |-> !ref_enable_o;
    endproperty
    a_off_disabled: assert property (p_off_disabled) else $error("ref on with status off");
    property p_pending_on;
        (ref_status_o == REF_PENDING) [*2] |-> ref_enable_o;
    endproperty
    a_pending_on: assert property (p_pending_on) else $error("ref off while pending");
    property p_settle_len;
        ref_status_o == REF_SETTLED && $past(ref_status_o) == REF_POWERING
            |-> pw_cnt >= SETTLE_CYCLES - 1 && pw_cnt <= SETTLE_CYCLES + 1;
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle time wrong");
    property p_settle_max;
        ref_status_o == REF_POWERING |-> pw_cnt <= SETTLE_CYCLES + 1;
    endproperty
    a_settle_max: assert property (p_settle_max) else $error("powering too long");
    property p_stretch_core;
        scl_oe_o |-> core_power_o;
    endproperty
    a_stretch_core: assert property (p_stretch_core) else $error("stretch with core off");
    property p_stretch_len;
        $fell(scl_oe_o) |-> str_cnt >= RES_BITS * STEP_CYCLES
            && str_cnt <= RES_BITS * STEP_CYCLES + 10;
    endproperty
    a_stretch_len: assert property (p_stretch_len) else $error("stretch length wrong");
    property p_core_down;
        $fell(scl_oe_o) |-> !core_power_o;
    endproperty
    a_core_down: assert property (p_core_down) else $error("core on after conversion");
    property p_first_bit;
        $fell(scl_oe_o) |-> sda_oe_o == !result_o[RES_BITS-1];
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first data bit wrong");
    property p_half_step;
        core_power_o && $past(core_power_o) |-> dac_half_step_o;
    endproperty
    a_half_step: assert property (p_half_step) else $error("half step offset missing");
    c_conv_done: cover property ($fell(scl_oe_o));
    c_ref_down: cover property (ref_status_o == REF_PENDING ##1 ref_status_o == REF_OFF);
    c_ext_conv: cover property (reference_adjust_input_i && scl_oe_o);
endmodule : adc_power_shutdown_control_sva
bind adc_power_shutdown_control adc_power_shutdown_control_sva #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
    .address_select_inputs_i(address_select_inputs_i),
    .reference_adjust_input_i(reference_adjust_input_i), .comparator_i(comparator_i),
    .dac_code_o(dac_code_o), .dac_half_step_o(dac_half_step_o),
    .core_power_o(core_power_o), .ref_enable_o(ref_enable_o),
    .ref_buffer_enable_o(ref_buffer_enable_o), .ref_status_o(ref_status_o),
    .result_o(result_o)
);

//--- tb/bus_master_model.sv
// Two-wire bus master model that reads conversion results
`timescale 1ns/1ps
module bus_master_model #(
    parameter int HALF = 8
)
(
    // Clock
    input wire logic clk_i,
    // Resolved lines
    input wire logic scl_i,
    input wire logic sda_i,
    // Pull-downs
    output logic scl_low_o,
    output logic sda_low_o,
    // Received byte
    output logic byte_vld_o,
    output logic [7:0] byte_o
);
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
        byte_vld_o = 1'b0;
        byte_o = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask : hold
    // Stretch wait is bounded; a stuck line is left to the watchdog
    task automatic rise_scl();
        scl_low_o <= 1'b0;
        hold(1);
        for (int i = 0; i < 2000 && scl_i !== 1'b1; i++) hold(1);
        hold(HALF / 2);
    endtask : rise_scl
    task automatic put_bit(input logic b);
        sda_low_o <= !b;
        hold(HALF);
        rise_scl();
        hold(HALF / 2);
        scl_low_o <= 1'b1;
        hold(1);
    endtask : put_bit
    task automatic get_bit(output logic b);
        sda_low_o <= 1'b0;
        hold(HALF);
        rise_scl();
        b = sda_i;
        hold(HALF / 2);
        scl_low_o <= 1'b1;
        hold(1);
    endtask : get_bit
    task automatic start_cond();
        sda_low_o <= 1'b1;
        hold(HALF);
        scl_low_o <= 1'b1;
        hold(HALF);
    endtask : start_cond
    task automatic stop_cond();
        sda_low_o <= 1'b1;
        hold(HALF);
        rise_scl();
        hold(HALF);
        sda_low_o <= 1'b0;
        hold(HALF);
    endtask : stop_cond
    task automatic send_addr(input logic [7:0] a, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(a[i]);
        get_bit(b);
        ack = !b;
    endtask : send_addr
    task automatic read_byte(input logic ack);
        logic [7:0] d;
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        byte_o <= d;
        byte_vld_o <= 1'b1;
        hold(1);
        byte_vld_o <= 1'b0;
        put_bit(!ack);
    endtask : read_byte
endmodule : bus_master_model

//--- tb/adc_power_shutdown_control_bench.sv
// Self-checking bench for the power and reference control
`timescale 1ns/1ps
module adc_power_shutdown_control_bench
    import adc_pwr_pkg::*;
;
    // Short settle keeps the run brief
    localparam int SETTLE = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_sel = 4'h0;
    logic ref_adjust = 1'b0;
    logic [14:0] vin_half = 15'h0;
    logic scl, sda, scl_low, sda_low, scl_oe, sda_oe, byte_vld, comparator;
    logic dac_half, core_power, ref_en, ref_buf;
    logic [7:0] rx_byte;
    logic [1:0] ref_status;
    logic [13:0] dac_code, result, last_res;
    logic [31:0] xs_state = 32'h985b;
    logic [15:0] exp_q[$];
    int n_mismatch = 0;
    int n_compared = 0;
    always #2.5 clk_i = ~clk_i;
    // Pull-ups win unless someone pulls low
    assign scl = !(scl_low || scl_oe);
    assign sda = !(sda_low || sda_oe);
    // Input in half steps against the offset trial level
    assign comparator = (vin_half >= {dac_code, dac_half});
    adc_power_shutdown_control #(.SETTLE_CYCLES(SETTLE)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .scl_oe_o(scl_oe), .sda_oe_o(sda_oe), .address_select_inputs_i(addr_sel),
        .reference_adjust_input_i(ref_adjust), .comparator_i(comparator),
        .dac_code_o(dac_code), .dac_half_step_o(dac_half), .core_power_o(core_power),
        .ref_enable_o(ref_en), .ref_buffer_enable_o(ref_buf), .ref_status_o(ref_status),
        .result_o(result)
    );
    bus_master_model #(.HALF(8)) u_master (
        .clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_low_o(scl_low),
        .sda_low_o(sda_low), .byte_vld_o(byte_vld), .byte_o(rx_byte)
    );
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        xs_state ^= xs_state << 13;
        xs_state ^= xs_state >> 17;
        xs_state ^= xs_state << 5;
        return xs_state;
    endfunction : xs
    function automatic logic [13:0] expect_code(input logic [14:0] v);
        return (v == 15'h0) ? 14'h0 : 14'((v - 15'h1) >> 1);
    endfunction : expect_code
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic frame(input logic rw, input int n, input logic [14:0] v0,
                         input logic [1:0] st_run, input logic [1:0] st_end);
        logic ack;
        logic [14:0] v;
        logic [13:0] r;
        v = v0;
        vin_half <= v;
        u_master.start_cond();
        u_master.send_addr({ADDR_FIXED, addr_sel, rw}, ack);
        repeat (3) @(posedge clk_i);
        check({14'h0, ack, core_power}, 16'h3);
        check(16'(scl_oe), 16'h1);
        check(16'(ref_status), 16'(st_run));
        for (int i = 0; i < n; i++) begin
            r = expect_code(v);
            last_res = r;
            exp_q.push_back({8'h0, r[13:6]});
            exp_q.push_back({8'h0, r[5:0], SUB_BITS});
            u_master.read_byte(1'b1);
            v = 15'(xs());
            vin_half <= v;
            u_master.read_byte(i < n - 1);
        end
        u_master.stop_cond();
        check(16'(core_power), 16'h0);
        check(16'(ref_status), 16'(st_end));
        check({14'h0, ref_en, ref_buf}, (st_end == REF_OFF) ? 16'h0 : 16'h3);
        check(16'(result), 16'(last_res));
    endtask : frame
    ////////////////////////////////////////
    always @(posedge clk_i) begin
        if (byte_vld === 1'b1) begin
            if (exp_q.size() > 0) check({8'h0, rx_byte}, exp_q.pop_front());
            else check({8'h0, rx_byte}, 16'hff00);
        end
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        end_sim();
    end
    initial begin
        logic ack;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        addr_sel <= 4'(xs());
        repeat (4) @(posedge clk_i);
        check({10'h0, core_power, ref_en, ref_buf, ref_status, scl_oe}, 16'h0);
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            u_master.start_cond();
            u_master.send_addr(k == 0 ? {3'h7, addr_sel, 1'b1}
                                      : {ADDR_FIXED, addr_sel ^ 4'h1, 1'b1}, ack);
            u_master.stop_cond();
            check({14'h0, ack, core_power}, 16'h0);
        end
        $display("test foreign address done");
        frame(1'b1, 3, 15'h0, REF_POWERING, REF_SETTLED);
        $display("test first conversions done");
        frame(1'b0, 2, 15'h1, REF_PENDING, REF_OFF);
        $display("test reference shutdown done");
        // full-scale conversion, longer than the settle time
        frame(1'b1, 1, 15'h7fff, REF_POWERING, REF_SETTLED);
        $display("test reference wake done");
        ref_adjust <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int k = 0; k < 2; k++) begin
            frame(1'(k), 1, 15'h2, REF_OFF, REF_OFF);
        end
        $display("test external mode done");
        check(16'(exp_q.size()), 16'h0);
        end_sim();
    end
endmodule : adc_power_shutdown_control_bench
